// file: design/smn_frame_checker.sv
// Receive-only serial monitor: deframes, checks, tags and reports bytes.
// Assumes line_i is the received bus level (1 = mark), synchronous to core_clk_i.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "smn_defines.svh"
module smn_frame_checker
  import smn_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        line_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rd_data_o,
  output logic             irq_o,
  output logic             entry_valid_o,
  output logic [8:0]       entry_data_o,
  output logic             entry_frame_err_o,
  output logic             entry_parity_err_o,
  output logic             entry_break_o,
  output logic [31:0]      entry_pos_o,
  output logic [31:0]      entry_stamp_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  smn_state_t  state_q;
  smn_state_t  state_d;
  logic [6:0]  ctrl_q;
  logic [15:0] div_q;
  logic [3:0]  status_q;
  logic [3:0]  status_d;
  logic [3:0]  mask_q;
  logic        line_q;
  logic        line_prev_q;
  logic        fall;
  logic [8:0]  shreg_q;
  logic [3:0]  bit_cnt_q;
  logic [3:0]  brk_cnt_q;
  logic        par_bit_q;
  logic [31:0] stamp_start_q;
  logic [31:0] stamp_now;
  logic [31:0] pos_now;
  logic        tick;
  logic        tmr_load;
  logic [15:0] tmr_val;
  logic        shift_en;
  logic        dlv;
  logic        dlv_frm;
  logic        dlv_brk;
  logic        dlv_par;
  logic        rx_en;
  logic        par_en;
  logic        par_odd;
  logic [3:0]  bits_cfg;
  logic [3:0]  nbits;
  logic [3:0]  rshift;
  logic [8:0]  data_aligned;
  logic        all_zero;
  logic        rd_status;

  assign rx_en    = ctrl_q[`SMN_CTRL_EN];
  assign par_en   = ctrl_q[`SMN_CTRL_PAR_EN];
  assign par_odd  = ctrl_q[`SMN_CTRL_PAR_ODD];
  assign bits_cfg = ctrl_q[`SMN_CTRL_BITS_HI:`SMN_CTRL_BITS_LO];

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  // Out of range widths are clamped so the bit counter always terminates
  always_comb begin
    if (bits_cfg < `SMN_BITS_MIN) begin
      nbits = `SMN_BITS_MIN;
    end else if (bits_cfg > `SMN_BITS_MAX) begin
      nbits = `SMN_BITS_MAX;
    end else begin
      nbits = bits_cfg;
    end
  end

  // Bits enter at the top, LSB first, so a short frame sits high in the shifter
  assign rshift       = `SMN_BITS_MAX - nbits;
  assign data_aligned = shreg_q >> rshift;
  assign all_zero     = (shreg_q == 9'h000) && !(par_en && par_bit_q);

  // Xor over data and parity bit is 1 for an odd count of ones
  assign dlv_par = par_en && !dlv_brk && ((^shreg_q) ^ par_bit_q ^ par_odd);

  // ----------------------------------------------------------------------
  // Line sampling and start edge
  // ----------------------------------------------------------------------
  // Registered once so the edge detector and sampler see one stable copy
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      line_q      <= 1'b1;
      line_prev_q <= 1'b1;
    end else begin
      line_q      <= line_i;
      line_prev_q <= line_q;
    end
  end

  assign fall = line_prev_q && !line_q;

  // ----------------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------------
  smn_bit_timer u_timer (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .load_i     (tmr_load),
    .load_val_i (tmr_val),
    .tick_o     (tick)
  );

  // Timestamp base, one count per clock cycle
  smn_counter u_stamp (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .inc_i      (1'b1),
    .value_o    (stamp_now)
  );

  // Position of the next entry; only delivered entries advance it
  smn_counter u_pos (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .inc_i      (dlv),
    .value_o    (pos_now)
  );

  // ----------------------------------------------------------------------
  // Receiver sequencing
  // ----------------------------------------------------------------------
  // Half a bit to the start centre, then whole bits from there on
  always_comb begin
    state_d  = state_q;
    tmr_load = 1'b0;
    tmr_val  = div_q;
    shift_en = 1'b0;
    dlv      = 1'b0;
    dlv_frm  = 1'b0;
    dlv_brk  = 1'b0;
    if (!rx_en) begin
      state_d = ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (fall) begin
            tmr_load = 1'b1;
            tmr_val  = {1'b0, div_q[15:1]};
            state_d  = ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            if (line_q) begin
              state_d = ST_IDLE; // Glitch, not a start bit
            end else begin
              tmr_load = 1'b1;
              state_d  = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (tick) begin
            shift_en = 1'b1;
            tmr_load = 1'b1;
            if (bit_cnt_q + 4'h1 == nbits) begin
              state_d = par_en ? ST_PARITY : ST_STOP;
            end
          end
        end
        ST_PARITY: begin
          if (tick) begin
            tmr_load = 1'b1;
            state_d  = ST_STOP;
          end
        end
        ST_STOP: begin
          if (tick) begin
            if (line_q) begin
              dlv     = 1'b1;
              state_d = ST_IDLE;
            end else if (all_zero) begin
              tmr_load = 1'b1;
              state_d  = ST_BREAK;
            end else begin
              dlv     = 1'b1;
              dlv_frm = 1'b1;
              state_d = ST_WAITHI;
            end
          end
        end
        ST_BREAK: begin
          if (line_q) begin
            dlv     = 1'b1; // Low stop but too short for a break
            dlv_frm = 1'b1;
            state_d = ST_IDLE;
          end else if (tick) begin
            tmr_load = 1'b1;
            if (brk_cnt_q + 4'h1 == `SMN_BREAK_EXTRA) begin
              dlv     = 1'b1;
              dlv_brk = 1'b1;
              state_d = ST_WAITHI;
            end
          end
        end
        ST_WAITHI: begin
          // A new start needs the line back at mark first
          if (line_q) begin
            state_d = ST_IDLE;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Data shifter and bit count, cleared at each start centre
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      shreg_q   <= 9'h000;
      bit_cnt_q <= 4'h0;
    end else if (state_q == ST_START) begin
      shreg_q   <= 9'h000;
      bit_cnt_q <= 4'h0;
    end else if (shift_en) begin
      shreg_q   <= {line_q, shreg_q[8:1]};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // Parity bit, taken at the centre of its slot
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      par_bit_q <= 1'b0;
    end else if (state_q == ST_START) begin
      par_bit_q <= 1'b0;
    end else if (state_q == ST_PARITY && tick) begin
      par_bit_q <= line_q;
    end
  end

  // Extra low bit times seen after the stop slot
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      brk_cnt_q <= 4'h0;
    end else if (state_q != ST_BREAK) begin
      brk_cnt_q <= 4'h0;
    end else if (tick) begin
      brk_cnt_q <= brk_cnt_q + 4'h1;
    end
  end

  // The moment of a byte is its start edge, not its delivery
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stamp_start_q <= 32'h0000_0000;
    end else if (state_q == ST_IDLE && fall) begin
      stamp_start_q <= stamp_now;
    end
  end

  // ----------------------------------------------------------------------
  // Entry stream
  // ----------------------------------------------------------------------
  // Last entry stays on the outputs; valid marks a new one for one cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      entry_valid_o      <= 1'b0;
      entry_data_o       <= 9'h000;
      entry_frame_err_o  <= 1'b0;
      entry_parity_err_o <= 1'b0;
      entry_break_o      <= 1'b0;
      entry_pos_o        <= 32'h0000_0000;
      entry_stamp_o      <= 32'h0000_0000;
    end else begin
      entry_valid_o <= dlv;
      if (dlv) begin
        entry_data_o       <= dlv_brk ? 9'h000 : data_aligned;
        entry_frame_err_o  <= dlv_frm;
        entry_parity_err_o <= dlv_par;
        entry_break_o      <= dlv_brk;
        entry_pos_o        <= pos_now;
        entry_stamp_o      <= stamp_start_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  // Control and divider; a divider below four gives unreliable centres
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_q <= `SMN_CTRL_RST;
      div_q  <= `SMN_DIV_RST;
      mask_q <= 4'h0;
    end else if (wr_i) begin
      if (addr_i == `SMN_ADDR_CTRL) begin
        ctrl_q <= wr_data_i[6:0];
      end
      if (addr_i == `SMN_ADDR_DIV) begin
        div_q <= wr_data_i[15:0];
      end
      if (addr_i == `SMN_ADDR_MASK) begin
        mask_q <= wr_data_i[3:0];
      end
    end
  end

  assign rd_status = rd_i && (addr_i == `SMN_ADDR_STATUS);

  // Sticky events; a read clears, but an event in that cycle survives
  always_comb begin
    status_d = rd_status ? 4'h0 : status_q;
    status_d[`SMN_ST_RX]  = status_d[`SMN_ST_RX]  | dlv;
    status_d[`SMN_ST_FRM] = status_d[`SMN_ST_FRM] | (dlv && dlv_frm);
    status_d[`SMN_ST_PAR] = status_d[`SMN_ST_PAR] | (dlv && dlv_par);
    status_d[`SMN_ST_BRK] = status_d[`SMN_ST_BRK] | (dlv && dlv_brk);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      status_q <= 4'h0;
    end else begin
      status_q <= status_d;
    end
  end

  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_q & mask_q);
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_data_o <= 32'h0000_0000;
    end else if (rd_i) begin
      unique case (addr_i)
        `SMN_ADDR_CTRL:   rd_data_o <= {25'h0, ctrl_q};
        `SMN_ADDR_DIV:    rd_data_o <= {16'h0, div_q};
        `SMN_ADDR_STATUS: rd_data_o <= {28'h0, status_q};
        `SMN_ADDR_MASK:   rd_data_o <= {28'h0, mask_q};
        `SMN_ADDR_ENTRY:  rd_data_o <= {20'h0, entry_break_o, entry_parity_err_o,
                                        entry_frame_err_o, entry_data_o};
        `SMN_ADDR_POS:    rd_data_o <= entry_pos_o;
        `SMN_ADDR_STAMP:  rd_data_o <= entry_stamp_o;
        `SMN_ADDR_LINE:   rd_data_o <= {24'h0, state_q, line_q};
        default:          rd_data_o <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_o <= 32'h0000_0000;
    end
  end

endmodule : smn_frame_checker

// file: design/smn_defines.svh
// Offsets, field positions, reset values and timing counts of the frame checker.
// Assumes byte addressing on a plain register port with 32-bit words.
// What this block does
// - Frame is start bit, five to nine data bits, optional parity, stop bit.
// - Falling edge of the start bit begins a frame and re-aligns bit sampling.
// - A frame not matching the configured layout is flagged as framing error.
// - Parity mismatch flags a parity error; the data value is still delivered.
// - Even mode needs an even count of ones over data plus parity bit.
// - Line low well beyond one character time is a break, delivered as zero.
// - Break entries carry their own flag, unlike a real zero byte.
// - Position counter counts every delivered entry, breaks included, never line level changes.
// - Every data entry carries a timestamp of the moment it occurred.
`ifndef SMN_DEFINES_SVH
`define SMN_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SMN_ADDR_CTRL    8'h00
`define SMN_ADDR_DIV     8'h04
`define SMN_ADDR_STATUS  8'h08
`define SMN_ADDR_MASK    8'h0c
`define SMN_ADDR_ENTRY   8'h10
`define SMN_ADDR_POS     8'h14
`define SMN_ADDR_STAMP   8'h18
`define SMN_ADDR_LINE    8'h1c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SMN_CTRL_EN      0
`define SMN_CTRL_BITS_LO 1
`define SMN_CTRL_BITS_HI 4
`define SMN_CTRL_PAR_EN  5
`define SMN_CTRL_PAR_ODD 6
`define SMN_ST_RX        0
`define SMN_ST_FRM       1
`define SMN_ST_PAR       2
`define SMN_ST_BRK       3
`define SMN_ENT_FRM      9
`define SMN_ENT_PAR      10
`define SMN_ENT_BRK      11

// ----------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------
`define SMN_CTRL_RST     7'h10
`define SMN_DIV_RST      16'h0364
`define SMN_BITS_MIN     4'h5
`define SMN_BITS_MAX     4'h9
`define SMN_BREAK_EXTRA  4'h2

`endif

// file: design/smn_pkg.sv
// Types shared by the frame checker files.
// Assumes the defines header is compiled alongside.
package smn_pkg;

  // Receiver states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_START  = 7'h02,
    ST_DATA   = 7'h04,
    ST_PARITY = 7'h08,
    ST_STOP   = 7'h10,
    ST_BREAK  = 7'h20,
    ST_WAITHI = 7'h40
  } smn_state_t;

endpackage : smn_pkg

// file: design/smn_counter.sv
// Free running 32-bit up counter with an increment enable.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module smn_counter (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        inc_i,
  output logic [31:0]      value_o
);

  // Wraps silently; software must allow for roll-over
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      value_o <= 32'h0000_0000;
    end else if (inc_i) begin
      value_o <= value_o + 32'h0000_0001;
    end
  end

endmodule : smn_counter

// file: design/smn_bit_timer.sv
// Reloadable down counter that pulses once when a loaded interval runs out.
// Assumes the loader reloads on every tick it wants to continue from.
`timescale 1ns/1ps
module smn_bit_timer (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        load_i,
  input  wire logic [15:0] load_val_i,
  output logic             tick_o
);

  logic [15:0] cnt_q;

  // A load of N gives a tick N cycles later; zero means stopped
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q <= 16'h0000;
    end else if (load_i) begin
      cnt_q <= load_val_i;
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // Plain compare: a loader that reloads on the tick must not feed back into it
  assign tick_o = (cnt_q == 16'h0001);

endmodule : smn_bit_timer

// file: sim/smn_frame_checker_sva.sv
// Port assertions for the frame checker.
// Assumes a bind onto smn_frame_checker from the bench top.
`timescale 1ns/1ps
`include "smn_defines.svh"
module smn_fc_sva (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  addr_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rd_data_o,
  input wire logic        irq_o,
  input wire logic        entry_valid_o,
  input wire logic [8:0]  entry_data_o,
  input wire logic        entry_frame_err_o,
  input wire logic        entry_parity_err_o,
  input wire logic        entry_break_o,
  input wire logic [31:0] entry_pos_o,
  input wire logic [31:0] entry_stamp_o
);
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  logic [31:0] cnt_q;
  logic [31:0] stamp_q;
  // Entries seen so far, the expected next position
  always_ff @(posedge core_clk_i) begin
    if (rst_i) cnt_q <= 32'h0;
    else if (entry_valid_o) cnt_q <= cnt_q + 32'h1;
  end
  // Last stamp, to see time only move forward
  always_ff @(posedge core_clk_i) begin
    if (rst_i) stamp_q <= 32'h0;
    else if (entry_valid_o) stamp_q <= entry_stamp_o;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Neither a status read nor a mask write, the only ways irq drops
  sequence s_no_clr;
    !(rd_i && addr_i == `SMN_ADDR_STATUS) && !(wr_i && addr_i == `SMN_ADDR_MASK);
  endsequence
  sequence s_irq_kept;
    s_no_clr ##1 (irq_o && !(rd_i && addr_i == `SMN_ADDR_STATUS)
      && !(wr_i && addr_i == `SMN_ADDR_MASK));
  endsequence
  a_pos_counts: assert property (entry_valid_o |-> entry_pos_o == cnt_q)
    else $error("position out of step");
  a_stamp_rises: assert property (entry_valid_o && cnt_q != 0 |-> entry_stamp_o > stamp_q)
    else $error("stamp did not advance");
  a_valid_pulse: assert property (entry_valid_o |=> !entry_valid_o [*8])
    else $error("entry pulse too close");
  a_entry_holds: assert property (!entry_valid_o |-> $stable(entry_data_o)
    && $stable(entry_pos_o) && $stable(entry_stamp_o))
    else $error("entry changed without valid");
  a_flags_hold: assert property (!entry_valid_o |-> $stable({entry_frame_err_o,
    entry_parity_err_o, entry_break_o}))
    else $error("flags changed without valid");
  a_break_zero: assert property (entry_valid_o && entry_break_o |-> entry_data_o == 9'h0)
    else $error("break data not zero");
  a_break_apart: assert property (entry_valid_o && entry_break_o |-> !entry_frame_err_o)
    else $error("break also marked frame");
  a_irq_kept: assert property (s_irq_kept |=> irq_o)
    else $error("irq dropped without clear");
  a_rd_idle_zero: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
    else $error("read data outside slot");
  c_break: cover property (entry_valid_o && entry_break_o);
endmodule : smn_fc_sva

// file: sim/smn_tx_node.sv
// Transmitting bus node model driving the monitored line.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module smn_tx_node (
  input  wire logic core_clk_i,
  output logic      line_o
);
  // ------------------------------------------------------------------
  // Line driving
  // ------------------------------------------------------------------
  initial line_o = 1'b1;
  // Hold a level for n cycles; a long low is how a break is made
  task automatic hold(input logic lvl, input int n);
    line_o <= lvl;
    repeat (n) @(posedge core_clk_i);
  endtask : hold
  // One frame, LSB first; badp flips parity, bads pulls stop low
  task automatic send(input logic [8:0] dat, input int nb, input logic pe,
                      input logic odd, input logic badp, input logic bads, input int d);
    logic p;
    p = ^(dat & ((9'h1 << nb) - 9'h1)) ^ odd ^ badp;
    hold(1'b0, d);
    for (int i = 0; i < nb; i++) hold(dat[i], d);
    if (pe) hold(p, d);
    hold(!bads, d);
    hold(1'b1, 1);
  endtask : send
endmodule : smn_tx_node

// file: sim/smn_frame_checker_tb_top.sv
// Self-checking bench for the frame checker.
// Assumes the design files and the node model are compiled first.
`timescale 1ns/1ps
`include "smn_defines.svh"
module smn_frame_checker_tb_top;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  localparam int D = 16; // Short bit time keeps the run brief
  logic        core_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, line_i;
  logic        irq_o, entry_valid_o, entry_frame_err_o, entry_parity_err_o, entry_break_o;
  logic [7:0]  addr_i = 8'h0;
  logic [8:0]  entry_data_o, dat;
  logic [3:0]  nb;
  logic [11:0] e, ee;
  logic [31:0] wr_data_i = 32'h0, rd_data_o, entry_pos_o, entry_stamp_o;
  logic [31:0] r, p, s, ps, t0, pt0, x = 32'h57b8, cyc = 32'h0;
  logic        bp, anyp = 1'b0;
  int          fail_count = 0, checks = 0, n, pm;
  logic [11:0] ent_q[$];
  logic [31:0] pos_q[$], stp_q[$];
  smn_frame_checker dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .line_i(line_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .irq_o(irq_o), .entry_valid_o(entry_valid_o),
    .entry_data_o(entry_data_o), .entry_frame_err_o(entry_frame_err_o),
    .entry_parity_err_o(entry_parity_err_o), .entry_break_o(entry_break_o),
    .entry_pos_o(entry_pos_o), .entry_stamp_o(entry_stamp_o));
  smn_tx_node tx (.core_clk_i(core_clk_i), .line_o(line_i));
  always #5 core_clk_i = ~core_clk_i;
  // Collect entries as they pulse; the valid stands one cycle only
  always @(posedge core_clk_i) begin
    cyc <= cyc + 32'h1;
    if (entry_valid_o === 1'b1) begin
      ent_q.push_back({entry_break_o, entry_parity_err_o, entry_frame_err_o, entry_data_o});
      pos_q.push_back(entry_pos_o);
      stp_q.push_back(entry_stamp_o);
    end
  end
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask : rd
  // Bounded wait for the next entry; a missing one ends the run
  task automatic get(output logic [11:0] ge, output logic [31:0] gp, output logic [31:0] gs);
    for (int i = 0; i < 64 * D && ent_q.size() == 0; i++) @(posedge core_clk_i);
    if (ent_q.size() == 0) begin
      fail_count++;
      finish_test();
    end else begin
      ge = ent_q.pop_front();
      gp = pos_q.pop_front();
      gs = stp_q.pop_front();
    end
  endtask : get
  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(`SMN_ADDR_CTRL, r); chk(r, 32'h10);
    rd(`SMN_ADDR_DIV, r); chk(r, 32'h364);
    rd(`SMN_ADDR_MASK, r); chk(r, 32'h0);
    rd(8'h20, r); chk(r, 32'h0);
    wr(`SMN_ADDR_DIV, D);
    wr(`SMN_ADDR_MASK, 32'hf);
    // Every width against none, even and odd parity, random data
    for (n = 0; n < 15; n++) begin
      r = rnd();
      nb = 4'(5 + n % 5);
      pm = n / 5;
      dat = r[8:0] & ((9'h1 << nb) - 9'h1);
      bp = r[9] & (pm != 0);
      anyp = anyp | bp;
      wr(`SMN_ADDR_CTRL, {25'h0, pm == 2, pm != 0, nb, 1'b1});
      t0 = cyc;
      tx.send(dat, nb, pm != 0, pm == 2, bp, 1'b0, D);
      get(e, p, s);
      ee = {1'b0, bp, 1'b0, dat};
      chk(e, ee);
      chk(p, n);
      if (n > 0) chk(s - ps, t0 - pt0);
      rd(`SMN_ADDR_ENTRY, r); chk(r, ee);
      ps = s;
      pt0 = t0;
    end
    chk(irq_o, 1'b1);
    rd(`SMN_ADDR_STATUS, r); chk(r, {29'h0, anyp, 2'b01});
    @(posedge core_clk_i);
    #1 chk(irq_o, 1'b0);
    // Low stop, real zero byte, then a break
    wr(`SMN_ADDR_CTRL, 32'h11);
    tx.send(9'h5a, 8, 1'b0, 1'b0, 1'b0, 1'b1, D);
    get(e, p, s); chk(e[9], 1'b1);
    tx.send(9'h0, 8, 1'b0, 1'b0, 1'b0, 1'b0, D);
    get(e, p, s); chk(e, 12'h0);
    tx.hold(1'b0, 16 * D);
    tx.hold(1'b1, 2 * D);
    get(e, p, s); chk(e, 12'h800);
    chk(p, 17);
    rd(`SMN_ADDR_STATUS, r); chk(r[3:1], 3'b101);
    rd(`SMN_ADDR_POS, r); chk(r, 32'h11);
    // Masked event keeps irq low until unmasked
    wr(`SMN_ADDR_MASK, 32'h0);
    tx.send(9'h33, 8, 1'b0, 1'b0, 1'b0, 1'b0, D);
    get(e, p, s);
    repeat (2) @(posedge core_clk_i);
    #1 chk(irq_o, 1'b0);
    wr(`SMN_ADDR_MASK, 32'h1);
    repeat (2) @(posedge core_clk_i);
    #1 chk(irq_o, 1'b1);
    // Disabled receiver records nothing
    wr(`SMN_ADDR_CTRL, 32'h10);
    tx.send(9'h0f, 8, 1'b0, 1'b0, 1'b0, 1'b0, D);
    repeat (4 * D) @(posedge core_clk_i);
    chk(ent_q.size(), 0);
    rd(`SMN_ADDR_LINE, r); chk(r, 32'h3);
    finish_test();
  end
endmodule : smn_frame_checker_tb_top
bind smn_frame_checker smn_fc_sva u_sva (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
  .entry_valid_o(entry_valid_o), .entry_data_o(entry_data_o),
  .entry_frame_err_o(entry_frame_err_o), .entry_parity_err_o(entry_parity_err_o),
  .entry_break_o(entry_break_o), .entry_pos_o(entry_pos_o), .entry_stamp_o(entry_stamp_o));
